// ==== verilog/pcg_pkg.sv ====
// Package for the PLL clock generator control block.
// Assumes a 32-bit APB master and an 8-bit register view in low bits.
package pcg_pkg;

   // Register byte offsets on the APB
   localparam logic [11:0] OFS_PLL_CONTROL       = 12'h000;
   localparam logic [11:0] OFS_BANDWIDTH_CONTROL = 12'h004;
   localparam logic [11:0] OFS_PLL_PROGRAMMING   = 12'h008;

   // Control register fields
   localparam int BIT_IRQ_ENABLE  = 7;
   localparam int BIT_LOCK_FLAG   = 6;
   localparam int BIT_PLL_ON      = 5;
   localparam int BIT_BASE_SELECT = 4;
   localparam logic [3:0] CTRL_LOW_ONES = 4'hF;

   // Bandwidth register fields
   localparam int BIT_AUTO_MODE    = 7;
   localparam int BIT_LOCK         = 6;
   localparam int BIT_ACQUISITION  = 5;
   localparam int BIT_CRYSTAL_LOSS = 4;

   // Programming register fields
   localparam int MUL_HI = 7;
   localparam int MUL_LO = 4;
   localparam int VRS_HI = 3;
   localparam int VRS_LO = 0;

   // Reset values
   localparam logic [3:0] RST_MULTIPLIER = 4'h6;
   localparam logic [3:0] RST_RANGE      = 4'h6;
   localparam logic       RST_PLL_ON     = 1'b1;

   // Timing counts
   localparam logic [1:0] SWITCH_EDGES = 2'h3;
   localparam logic [5:0] LOSS_FACTOR  = 6'h04;

   // Base clock selector states
   typedef enum logic {CLK_RUN, CLK_SWITCH} pcg_clk_e;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pcg_apb_req_s;

   // APB answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } pcg_apb_rsp_s;

endpackage : pcg_pkg

// ==== verilog/pcg_clock_gen_control.sv ====
// Control and status logic of the PLL clock generator.
// Assumes crystal, VCO, lock and tracking inputs arrive asynchronously,
// and that both clocks run well below a quarter of mclk.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module pcg_clock_gen_control
(
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire pcg_pkg::pcg_apb_req_s apbReq,
   output var  pcg_pkg::pcg_apb_rsp_s apbRsp,
   input  wire logic                  oscEnableIn,
   input  wire logic                  crystalClock,
   input  wire logic                  vcoClock,
   input  wire logic                  lockIn,
   input  wire logic                  trackIn,
   output logic                       baseClockOut,
   output logic                       lockIrq,
   output logic                       oscRun,
   output logic                       pllEnable,
   output logic                       autoMode,
   output logic                       filterTrack,
   output logic [3:0]                 feedbackMultiplier,
   output logic [3:0]                 rangeMultiplier
);

   // Effective feedback multiplier, zero acts as one
   function automatic logic [3:0] mulEff(input logic [3:0] m);
      mulEff = (m == 4'h0) ? 4'h1 : m;
   endfunction : mulEff

   // Synchroniser stages: first stage read only by second
   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic [4:0] prev_ff;
   logic       oscS;
   logic       xS;
   logic       vS;
   logic       lockS;
   logic       trackS;
   logic       xEdge;
   logic       vEdge;

   // Register state
   logic       irqEn_ff;
   logic       flag_ff;
   logic       pll_on_a_ff;
   logic       bcs_ff;
   logic       auto_ff;
   logic       acqMan_ff;
   logic       xldRes_ff;
   logic       xldRun_ff;
   logic [5:0] xldCnt_ff;
   logic [3:0] mul_ff;
   logic [3:0] vrs_ff;
   logic       pready_ff;
   logic       pslverr_ff;
   logic [31:0] prdata_ff;
   logic       irq_ff;
   logic       pllEn_ff;
   logic       filt_ff;

   logic       nxt_irqEn;
   logic       nxt_flag;
   logic       nxt_pll_on_a;
   logic       nxt_bcs;
   logic       nxt_auto;
   logic       nxt_acqMan;
   logic       nxt_xldRes;
   logic       nxt_xldRun;
   logic [5:0] nxt_xldCnt;
   logic [3:0] nxt_mul;
   logic [3:0] nxt_vrs;
   logic       nxt_pready;
   logic       nxt_pslverr;
   logic [31:0] nxt_prdata;
   logic       nxt_irq;
   logic       nxt_pllEn;
   logic       nxt_filt;

   // Clock selector state
   pcg_pkg::pcg_clk_e clkSt_ff;
   pcg_pkg::pcg_clk_e nxt_clkSt;
   logic       src_ff;
   logic       nxt_src;
   logic [1:0] xCnt_ff;
   logic [1:0] vCnt_ff;
   logic [1:0] nxt_xCnt;
   logic [1:0] nxt_vCnt;
   logic       out_ff;
   logic       nxt_out;

   // Bus decode helpers
   logic       access;
   logic       wrDone;
   logic       rdDone;
   logic       selCtrl;
   logic       selBw;
   logic       selProg;
   logic       mapped;
   logic [7:0] rdByte;
   logic [7:0] wd;
   logic       lockBit;
   logic       lockChg;
   logic       rangeOk;
   logic [5:0] lossLimit;

   assign oscS   = sync_ff[0];
   assign xS     = sync_ff[1];
   assign vS     = sync_ff[2];
   assign lockS  = sync_ff[3];
   assign trackS = sync_ff[4];

   // Edge detection works on the second stage only
   assign xEdge = xS & ~prev_ff[1];
   assign vEdge = vS & ~prev_ff[2];

   // Two-stage synchronisers for all asynchronous inputs
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         meta_ff <= 5'h00;
         sync_ff <= 5'h00;
         prev_ff <= 5'h00;
      end
      else if (ce)
      begin
         meta_ff <= {trackIn, lockIn, vcoClock, crystalClock, oscEnableIn};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Bus phase decode
   assign access  = apbReq.psel & apbReq.penable;
   assign wrDone  = access & pready_ff & apbReq.pwrite;
   assign rdDone  = access & pready_ff & ~apbReq.pwrite;
   assign selCtrl = (apbReq.paddr == pcg_pkg::OFS_PLL_CONTROL);
   assign selBw   = (apbReq.paddr == pcg_pkg::OFS_BANDWIDTH_CONTROL);
   assign selProg = (apbReq.paddr == pcg_pkg::OFS_PLL_PROGRAMMING);
   assign mapped  = selCtrl | selBw | selProg;
   assign wd      = apbReq.pwdata[7:0];

   // Lock status and change detection in the bus clock domain
   assign lockBit = auto_ff & lockS;
   assign lockChg = auto_ff & (lockS ^ prev_ff[3]);
   assign rangeOk = (vrs_ff != 4'h0);
   assign lossLimit = {2'h0, mulEff(mul_ff)} * pcg_pkg::LOSS_FACTOR;

   // Read data mux
   always_comb
   begin
      rdByte = 8'h00;
      if (selCtrl)
      begin
         rdByte[pcg_pkg::BIT_IRQ_ENABLE]  = irqEn_ff & auto_ff;
         rdByte[pcg_pkg::BIT_LOCK_FLAG]   = flag_ff & auto_ff;
         rdByte[pcg_pkg::BIT_PLL_ON]      = pll_on_a_ff;
         rdByte[pcg_pkg::BIT_BASE_SELECT] = bcs_ff;
         rdByte[3:0] = pcg_pkg::CTRL_LOW_ONES;
      end
      else if (selBw)
      begin
         rdByte[pcg_pkg::BIT_AUTO_MODE] = auto_ff;
         rdByte[pcg_pkg::BIT_LOCK]      = lockBit;
         rdByte[pcg_pkg::BIT_ACQUISITION] =
            auto_ff ? trackS : acqMan_ff;
         rdByte[pcg_pkg::BIT_CRYSTAL_LOSS] = xldRes_ff & bcs_ff;
      end
      else if (selProg)
      begin
         rdByte = {mul_ff, vrs_ff};
      end
   end

   // Register file and status next values
   always_comb
   begin
      nxt_irqEn   = irqEn_ff;
      nxt_pll_on_a   = pll_on_a_ff;
      nxt_bcs     = bcs_ff;
      nxt_auto    = auto_ff;
      nxt_acqMan  = acqMan_ff;
      nxt_xldRes  = xldRes_ff;
      nxt_xldRun  = xldRun_ff;
      nxt_xldCnt  = xldCnt_ff;
      nxt_mul     = mul_ff;
      nxt_vrs     = vrs_ff;
      nxt_pready  = access & ~pready_ff;
      nxt_pslverr = access & ~pready_ff & ~mapped;
      nxt_prdata  = prdata_ff;
      if (access & ~pready_ff)
      begin
         nxt_prdata = apbReq.pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
      end
      // Control register write with interlocks
      if (wrDone & selCtrl)
      begin
         if (auto_ff)
         begin
            nxt_irqEn = wd[pcg_pkg::BIT_IRQ_ENABLE];
         end
         if (wd[pcg_pkg::BIT_PLL_ON] | ~bcs_ff)
         begin
            nxt_pll_on_a = wd[pcg_pkg::BIT_PLL_ON];
         end
         if (~wd[pcg_pkg::BIT_BASE_SELECT] | (pll_on_a_ff & rangeOk))
         begin
            nxt_bcs = wd[pcg_pkg::BIT_BASE_SELECT];
         end
      end
      // Bandwidth register write; test bits are not stored
      if (wrDone & selBw)
      begin
         nxt_auto = wd[pcg_pkg::BIT_AUTO_MODE];
         if (~auto_ff)
         begin
            nxt_acqMan = wd[pcg_pkg::BIT_ACQUISITION];
         end
         if (wd[pcg_pkg::BIT_CRYSTAL_LOSS] & bcs_ff)
         begin
            nxt_xldRes = 1'b1;
            nxt_xldRun = 1'b1;
            nxt_xldCnt = 6'h00;
         end
         else if (~wd[pcg_pkg::BIT_CRYSTAL_LOSS])
         begin
            nxt_xldRes = 1'b0;
            nxt_xldRun = 1'b0;
         end
      end
      // Programming register locked while the PLL is on
      if (wrDone & selProg & ~pll_on_a_ff)
      begin
         nxt_mul = wd[pcg_pkg::MUL_HI:pcg_pkg::MUL_LO];
         nxt_vrs = wd[pcg_pkg::VRS_HI:pcg_pkg::VRS_LO];
      end
      // Crystal-loss check counts VCO edges up to N times four
      if (xldRun_ff)
      begin
         if (xEdge | ~bcs_ff)
         begin
            nxt_xldRes = 1'b0;
            nxt_xldRun = 1'b0;
         end
         else if (xldCnt_ff >= lossLimit)
         begin
            nxt_xldRun = 1'b0;
         end
         else if (vEdge)
         begin
            nxt_xldCnt = xldCnt_ff + 6'h01;
         end
      end
      // Stop or zero range forces the crystal clock
      if (~oscS | ~rangeOk)
      begin
         nxt_bcs = 1'b0;
      end
      // Lock flag: set wins over read clear
      nxt_flag = auto_ff & (lockChg |
         (flag_ff & ~(rdDone & selCtrl)));
      nxt_irq   = oscS & auto_ff & flag_ff & irqEn_ff;
      nxt_pllEn = oscS & pll_on_a_ff & rangeOk;
      nxt_filt  = auto_ff ? trackS : acqMan_ff;
   end

   // Register file flip-flops
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         irqEn_ff   <= 1'b0;
         flag_ff    <= 1'b0;
         pll_on_a_ff   <= pcg_pkg::RST_PLL_ON;
         bcs_ff     <= 1'b0;
         auto_ff    <= 1'b0;
         acqMan_ff  <= 1'b0;
         xldRes_ff  <= 1'b0;
         xldRun_ff  <= 1'b0;
         xldCnt_ff  <= 6'h00;
         mul_ff     <= pcg_pkg::RST_MULTIPLIER;
         vrs_ff     <= pcg_pkg::RST_RANGE;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         irq_ff     <= 1'b0;
         pllEn_ff   <= 1'b0;
         filt_ff    <= 1'b0;
      end
      else if (ce)
      begin
         irqEn_ff   <= nxt_irqEn;
         flag_ff    <= nxt_flag;
         pll_on_a_ff   <= nxt_pll_on_a;
         bcs_ff     <= nxt_bcs;
         auto_ff    <= nxt_auto;
         acqMan_ff  <= nxt_acqMan;
         xldRes_ff  <= nxt_xldRes;
         xldRun_ff  <= nxt_xldRun;
         xldCnt_ff  <= nxt_xldCnt;
         mul_ff     <= nxt_mul;
         vrs_ff     <= nxt_vrs;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff  <= nxt_prdata;
         irq_ff     <= nxt_irq;
         pllEn_ff   <= nxt_pllEn;
         filt_ff    <= nxt_filt;
      end
   end

   // Base clock selector: hold output while the crystal and, if the PLL is enabled, the VCO settle
   always_comb
   begin
      nxt_clkSt = clkSt_ff;
      nxt_src   = src_ff;
      nxt_xCnt  = xCnt_ff;
      nxt_vCnt  = vCnt_ff;
      nxt_out   = out_ff;
      case (clkSt_ff)
         pcg_pkg::CLK_RUN:
         begin
            if (src_ff != bcs_ff)
            begin
               nxt_clkSt = pcg_pkg::CLK_SWITCH;
               nxt_xCnt  = 2'h0;
               nxt_vCnt  = 2'h0;
            end
            else if (src_ff ? vEdge : xEdge)
            begin
               nxt_out = ~out_ff;
            end
         end
         pcg_pkg::CLK_SWITCH:
         begin
            if (xEdge && xCnt_ff != pcg_pkg::SWITCH_EDGES)
            begin
               nxt_xCnt = xCnt_ff + 2'h1;
            end
            if (vEdge && vCnt_ff != pcg_pkg::SWITCH_EDGES)
            begin
               nxt_vCnt = vCnt_ff + 2'h1;
            end
            if (xCnt_ff == pcg_pkg::SWITCH_EDGES &&
                (vCnt_ff == pcg_pkg::SWITCH_EDGES || !pllEn_ff))
            begin
               nxt_src   = bcs_ff;
               nxt_clkSt = pcg_pkg::CLK_RUN;
            end
         end
         default:
         begin
            nxt_clkSt = pcg_pkg::CLK_RUN;
         end
      endcase
      // Stop holds the output low on the crystal source
      if (~oscS)
      begin
         nxt_clkSt = pcg_pkg::CLK_RUN;
         nxt_src   = 1'b0;
         nxt_out   = 1'b0;
      end
   end

   // Base clock selector flip-flops
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         clkSt_ff <= pcg_pkg::CLK_RUN;
         src_ff   <= 1'b0;
         xCnt_ff  <= 2'h0;
         vCnt_ff  <= 2'h0;
         out_ff   <= 1'b0;
      end
      else if (ce)
      begin
         clkSt_ff <= nxt_clkSt;
         src_ff   <= nxt_src;
         xCnt_ff  <= nxt_xCnt;
         vCnt_ff  <= nxt_vCnt;
         out_ff   <= nxt_out;
      end
   end

   // Outputs straight from flip-flops
   assign apbRsp.prdata      = prdata_ff;
   assign apbRsp.pready      = pready_ff;
   assign apbRsp.pslverr     = pslverr_ff;
   assign baseClockOut       = out_ff;
   assign lockIrq            = irq_ff;
   assign oscRun             = oscS;
   assign pllEnable          = pllEn_ff;
   assign autoMode           = auto_ff;
   assign filterTrack        = filt_ff;
   assign feedbackMultiplier = mul_ff;
   assign rangeMultiplier    = vrs_ff;

endmodule : pcg_clock_gen_control

`default_nettype wire

// ==== sim/pcg_clock_gen_control_properties.sv ====
// Checker for the PLL clock generator control block.
// Bound to the block's top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pcg_clock_gen_control_properties
(
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire pcg_pkg::pcg_apb_req_s apbReq,
   input wire pcg_pkg::pcg_apb_rsp_s apbRsp,
   input wire logic                  baseClockOut,
   input wire logic                  lockIrq,
   input wire logic                  oscRun,
   input wire logic                  pllEnable,
   input wire logic                  autoMode,
   input wire logic [3:0]            feedbackMultiplier,
   input wire logic [3:0]            rangeMultiplier
);
   // Completed transfers and their targets
   wire logic done  = apbRsp.pready;
   wire logic rdCtl = done && !apbReq.pwrite && apbReq.paddr == pcg_pkg::OFS_PLL_CONTROL;
   wire logic rdBw  = done && !apbReq.pwrite && apbReq.paddr == 12'h004;
   wire logic hit   = apbReq.paddr inside {12'h000, 12'h004, 12'h008};

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Bus timing, register views and interlocks
   a_one_wait: assert property (apbReq.psel && apbReq.penable && !done |=> done)
      else $error("bus answer not after one wait state");
   a_bad_addr: assert property (done && !hit |-> apbRsp.pslverr && (apbReq.pwrite || apbRsp.prdata == 32'h0))
      else $error("unmapped access not refused");
   a_ctl_ones: assert property (rdCtl |-> apbRsp.prdata[3:0] == pcg_pkg::CTRL_LOW_ONES)
      else $error("control low bits not ones");
   a_manual_ctl: assert property (rdCtl && !autoMode |-> apbRsp.prdata[7:6] == 2'h0)
      else $error("enable or flag visible in manual mode");
   a_manual_lock: assert property (rdBw && !autoMode |-> !apbRsp.prdata[6])
      else $error("lock visible in manual mode");
   a_irq_auto: assert property (!autoMode ##1 !autoMode |-> !lockIrq)
      else $error("interrupt in manual mode");
   a_pll_gate: assert property (pllEnable |-> $past(oscRun) && $past(rangeMultiplier) != 4'h0)
      else $error("PLL enabled without oscillator or range");
   a_prog_hold: assert property ($changed(feedbackMultiplier) || $changed(rangeMultiplier) |-> !$past(pllEnable))
      else $error("programming changed with PLL on");
   a_stop_quiet: assert property (!oscRun [*3] |-> !baseClockOut && !pllEnable && !lockIrq)
      else $error("outputs active while stopped");

   // Main scenarios reached
   c_flag_read: cover property (rdCtl && apbRsp.prdata[6]);
   c_irq: cover property ($rose(lockIrq));
   c_error: cover property (done && apbRsp.pslverr);
endmodule : pcg_clock_gen_control_properties

bind pcg_clock_gen_control pcg_clock_gen_control_properties chk_u
(
   .mclk, .rst, .apbReq, .apbRsp, .baseClockOut, .lockIrq, .oscRun, .pllEnable, .autoMode,
   .feedbackMultiplier, .rangeMultiplier
);
`default_nettype wire

// ==== sim/pcg_analog_model.sv ====
// Crystal and VCO stand-in for the clock generator control block.
// Both run slower than a quarter of the bus clock; stopped clocks rest low.
`timescale 1ns/10ps
`default_nettype none
module pcg_analog_model
#(
   parameter int XHALF = 350,
   parameter int VHALF = 200
)
(
   input  wire logic oscEn,
   input  wire logic vcoEn,
   input  wire logic xStop,
   output var  logic xClk,
   output var  logic vClk
);
   // Crystal runs only while enabled and not cut off
   initial xClk = 1'b0;
   always #(XHALF) xClk = oscEn && !xStop ? !xClk : 1'b0;
   // VCO runs only while the block enables the PLL
   initial vClk = 1'b0;
   always #(VHALF) vClk = vcoEn ? !vClk : 1'b0;
endmodule : pcg_analog_model
`default_nettype wire

// ==== sim/pcg_clock_gen_control_bench.sv ====
// Self-checking bench for the PLL clock generator control block.
// Drives APB and status inputs; the model makes both clocks.
`timescale 1ns/10ps
`default_nettype none
module pcg_clock_gen_control_bench;
   localparam logic [11:0] CTL = pcg_pkg::OFS_PLL_CONTROL;
   localparam logic [11:0] BW  = pcg_pkg::OFS_BANDWIDTH_CONTROL;
   localparam logic [11:0] PRG = pcg_pkg::OFS_PLL_PROGRAMMING;
   localparam int          XH  = 350;
   localparam int          VH  = 200;
   logic                  mclk, rst, ce, oscEnableIn, lockIn, trackIn, xStop, lastErr, moved;
   logic [7:0]            q;
   pcg_pkg::pcg_apb_req_s apbReq;
   pcg_pkg::pcg_apb_rsp_s apbRsp;
   wire logic             crystalClock, vcoClock, baseClockOut, lockIrq, oscRun;
   wire logic             pllEnable, autoMode, filterTrack;
   wire logic [3:0]       feedbackMultiplier, rangeMultiplier;
   int                    fails, numChecks, cycles;

   pcg_clock_gen_control dut_u
   (
      .mclk, .rst, .ce, .apbReq, .apbRsp, .oscEnableIn, .crystalClock, .vcoClock, .lockIn,
      .trackIn, .baseClockOut, .lockIrq, .oscRun, .pllEnable, .autoMode, .filterTrack,
      .feedbackMultiplier, .rangeMultiplier
   );
   pcg_analog_model #(.XHALF(XH), .VHALF(VH)) model_u
   (
      .oscEn(oscEnableIn), .vcoEn(pllEnable), .xStop, .xClk(crystalClock), .vClk(vcoClock)
   );

   // Bus clock
   always #25 mclk = !mclk;

   // Cuts a hang short
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         $display("[FAIL] %0t run took too long", $time);
         conclude();
      end
   end

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      numChecks = numChecks + 1;
      if (s !== e)
      begin
         fails = fails + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : check

   // One APB transfer; waits for pready and keeps the read data
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      do
         @(posedge mclk);
      while (apbRsp.pready !== 1'b1);
      q = apbRsp.prdata[7:0];
      lastErr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(q, e);
   endtask : rdc

   // High time and low time of the base clock against one half period
   task automatic measure(input int h);
      realtime t0, t1, t2;
      @(posedge baseClockOut) t0 = $realtime;
      @(negedge baseClockOut) t1 = $realtime;
      @(posedge baseClockOut) t2 = $realtime;
      check(t1 - t0 > h - 60 && t1 - t0 < h + 60 && t2 - t1 > h - 60 && t2 - t1 < h + 60, 1);
   endtask : measure

   task automatic tReset();
      rdc(CTL, 8'h2F);
      rdc(BW, 8'h00);
      rdc(PRG, 8'h66);
      wr(12'h00C, 8'hFF);
      check(lastErr, 1'b1);
      rdc(12'h00C, 8'h00);
      check(lastErr, 1'b1);
      $display("reset and bus test done");
   endtask : tReset

   task automatic tInterlock();
      wr(CTL, 8'h30);
      rdc(CTL, 8'h3F);
      wr(CTL, 8'h00);
      rdc(CTL, 8'h2F);
      wr(CTL, 8'h00);
      wr(CTL, 8'h10);
      rdc(CTL, 8'h0F);
      $display("interlock test done");
   endtask : tInterlock

   task automatic tProgram();
      wr(PRG, 8'h00);
      rdc(PRG, 8'h00);
      check(feedbackMultiplier, 4'h0);
      check(rangeMultiplier, 4'h0);
      wr(CTL, 8'h30);
      rdc(CTL, 8'h2F);
      check(pllEnable, 1'b0);
      wr(PRG, 8'h55);
      rdc(PRG, 8'h00);
      wr(CTL, 8'h00);
      wr(PRG, 8'h66);
      wr(CTL, 8'h20);
      repeat (3) @(posedge mclk);
      check(pllEnable, 1'b1);
      $display("programming test done");
   endtask : tProgram

   task automatic tLock();
      wr(BW, 8'h20);
      wr(BW, 8'hA0);
      wr(CTL, 8'hA0);
      lockIn <= 1'b1;
      trackIn <= 1'b1;
      repeat (6) @(posedge mclk);
      check(autoMode, 1'b1);
      check(lockIrq, 1'b1);
      rdc(BW, 8'hE0);
      rdc(CTL, 8'hEF);
      rdc(CTL, 8'hAF);
      repeat (2) @(posedge mclk);
      check(lockIrq, 1'b0);
      trackIn <= 1'b0;
      lockIn <= 1'b0;
      wr(BW, 8'h00);
      rdc(CTL, 8'h2F);
      repeat (2) @(posedge mclk);
      check(filterTrack, 1'b1);
      wr(CTL, 8'hA0);
      rdc(CTL, 8'h2F);
      wr(BW, 8'h00);
      repeat (2) @(posedge mclk);
      check(filterTrack, 1'b0);
      $display("lock test done");
   endtask : tLock

   task automatic tSwitch();
      measure(2 * XH);
      wr(CTL, 8'h30);
      q[0] = baseClockOut;
      moved = 1'b0;
      repeat (20) @(posedge mclk) moved = moved || (baseClockOut !== q[0]);
      check(moved, 1'b0);
      repeat (80) @(posedge mclk);
      measure(2 * VH);
      $display("clock switch test done");
   endtask : tSwitch

   task automatic tLoss();
      wr(BW, 8'h10);
      repeat (200) @(posedge mclk);
      rdc(BW, 8'h00);
      xStop <= 1'b1;
      repeat (20) @(posedge mclk);
      wr(BW, 8'h10);
      repeat (200) @(posedge mclk);
      rdc(BW, 8'h10);
      xStop <= 1'b0;
      wr(CTL, 8'h20);
      wr(BW, 8'h10);
      rdc(BW, 8'h00);
      $display("crystal loss test done");
   endtask : tLoss

   task automatic tStop();
      wr(CTL, 8'h30);
      repeat (80) @(posedge mclk);
      oscEnableIn <= 1'b0;
      repeat (8) @(posedge mclk);
      check({oscRun, pllEnable, baseClockOut}, 3'h0);
      rdc(CTL, 8'h2F);
      oscEnableIn <= 1'b1;
      repeat (6) @(posedge mclk);
      rdc(CTL, 8'h2F);
      // Clock enable low freezes the divider on the running crystal
      ce <= 1'b0;
      repeat (2) @(posedge mclk);
      q[0] = baseClockOut;
      moved = 1'b0;
      repeat (40) @(posedge mclk) moved = moved || (baseClockOut !== q[0]);
      check(moved, 1'b0);
      ce <= 1'b1;
      repeat (2) @(posedge mclk);
      $display("stop test done");
   endtask : tStop

   task automatic conclude();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // Main sequence
   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      oscEnableIn = 1'b1;
      lockIn = 1'b0;
      trackIn = 1'b0;
      xStop = 1'b0;
      apbReq = '0;
      fails = 0;
      numChecks = 0;
      cycles = 0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      tReset();
      tInterlock();
      tProgram();
      tLock();
      tSwitch();
      tLoss();
      tStop();
      conclude();
   end
endmodule : pcg_clock_gen_control_bench
`default_nettype wire
